// ===== logic/ast_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package ast_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] AST_OFS_CTRL    = 8'h00;
  localparam logic [7:0] AST_OFS_STATUS  = 8'h04;
  localparam logic [7:0] AST_OFS_TXDATA  = 8'h08;
  localparam logic [7:0] AST_OFS_RXDATA  = 8'h0c;
  localparam logic [7:0] AST_OFS_DIVISOR = 8'h10;

  // ************************************************************
  // Control field positions
  // ************************************************************
  localparam int AST_CTL_PORT_EN   = 0;
  localparam int AST_CTL_CONTINUOUS_RECEIVE_ENABLE      = 1;
  localparam int AST_CTL_SYNC      = 2;
  localparam int AST_CTL_TRANSMIT_ENABLE      = 3;
  localparam int AST_CTL_TX9       = 4;
  localparam int AST_CTL_TRANSMIT_NINTH_BIT      = 5;
  localparam int AST_CTL_TXINV     = 6;
  localparam int AST_CTL_RX9       = 7;
  localparam int AST_CTL_ADDRESS_FILTER_ENABLE     = 8;
  localparam int AST_CTL_HISPEED   = 9;
  localparam int AST_CTL_WIDE      = 10;
  localparam int AST_CTL_RECEIVE_IRQ_ENABLE      = 11;
  localparam int AST_CTL_TRANSMIT_IRQ_ENABLE      = 12;
  localparam int AST_CTL_PERIPHERAL_IRQ_ENABLE      = 13;
  localparam int AST_CTL_GIE       = 14;
  localparam int AST_CTL_WIDTH     = 15;

  // ************************************************************
  // Status field positions
  // ************************************************************
  localparam int AST_STS_RECEIVE_PENDING_FLAG  = 0;
  localparam int AST_STS_FRAME_ERROR_FLAG  = 1;
  localparam int AST_STS_OVERFLOW_ERROR_FLAG  = 2;
  localparam int AST_STS_RECEIVE_NINTH_BIT  = 3;
  localparam int AST_STS_TRANSMIT_BUFFER_FREE_FLAG  = 4;
  localparam int AST_STS_TRMT  = 5;
  localparam int AST_STS_RXIDL = 6;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [14:0] AST_CTRL_RST    = 15'h0000;
  localparam logic [15:0] AST_DIVISOR_RST = 16'h0000;
  localparam int          AST_OVERSAMPLE  = 16;
  localparam int          AST_FIFO_DEPTH  = 2;
  localparam logic [1:0]  AST_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  AST_RESP_SLVERR = 2'b10;

endpackage

// ===== logic/ast_rx_fifo.sv
// Two-entry receive character memory with registered read data.
`timescale 1ns/1ps
module ast_rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             clear,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic             pop,
  output logic [WIDTH-1:0]      head_q,
  output logic                  not_empty_q,
  output logic                  full_q
);

  // The pointer logic is one bit wide, so only a depth of two can be served.
  if (DEPTH != 2) begin : g_depth_check
    $error("ast_rx_fifo supports a depth of two only");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             rd_q;
  logic             wr_q;
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             do_push;
  logic             do_pop;

  assign do_pop  = pop && (cnt_q != 2'd0);
  assign do_push = push && ((cnt_q != 2'd2) || do_pop);
  assign cnt_d   = cnt_q + {1'b0, do_push} - {1'b0, do_pop};

  always_ff @(posedge aclk) begin
    if (clear) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (do_push) begin
        mem_q[wr_q] <= wdata;
        wr_q        <= ~wr_q;
      end
      if (do_pop) rd_q <= ~rd_q;
      cnt_q <= cnt_d;
    end
  end

  // Head is registered so that status bits follow the oldest entry a cycle after a change.
  always_ff @(posedge aclk) begin
    if (clear) begin
      head_q      <= '0;
      not_empty_q <= 1'b0;
      full_q      <= 1'b0;
    end else begin
      not_empty_q <= cnt_d != 2'd0;
      full_q      <= cnt_d == 2'd2;
      if (cnt_d == 2'd0) head_q <= '0;
      else if (do_pop) head_q <= (cnt_q == 2'd2) ? mem_q[~rd_q] : wdata;
      else if (cnt_q == 2'd0) head_q <= wdata;
    end
  end

endmodule

// ===== logic/ast_uart.sv
// Asynchronous serial transceiver with AXI4-Lite register access.
`timescale 1ns/1ps
// Behaviour
// - Receive line is sampled at sixteen ticks per bit; shifter advances once per bit.
// - A completed character moves at once into a two-entry receive FIFO.
// - Falling edge starts reception; line rechecked at half bit, high aborts silently.
// - After valid start, each bit centre one bit apart, majority voted, shifted in.
// - Stop position sampled one bit later; low marks character with framing error.
// - At the stop bit centre the character is pushed and receive pending rises.
// - Receive pending is high when receiver enabled and FIFO not empty; read-only.
// - Reading receive data returns oldest character and removes it.
// - Each entry keeps its framing bit; status shows the oldest entry.
// - Framing error does not stop reception, interrupt, or need clearing.
// - Port disable resets port and clears frame error; receive disable does not.
// - Third character with FIFO full sets overrun; further characters are refused.
// - Overrun clears on receive disable or port disable.
// - Ninth-bit reception shifts nine bits; ninth-bit status follows oldest entry.
// - Address filter with nine bits keeps only characters whose ninth bit is one.
// - Receiver runs only with receive enable, asynchronous mode and port enable.
// - Setting transmit enable sets the transmit buffer free flag.
// - Configuration first; writing the transmit holding register starts transmission.
// - Transmit ninth bit is loaded before the byte; one marks an address.
// - With the port enabled, transmit invert inverts the whole transmit output, idle included; port disable holds it high.
// - Receive interrupt needs pending, receive, peripheral and global enables all set.
// - Data bits go and come least significant bit first.
// - Frame is low start, eight or nine data bits, high stop; idle high.
// - Held character moves to shift register within one cycle after stop.
// - Buffer free flag is set when transmitter enabled and holding register empty.
module ast_uart
  import ast_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address, data and response
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Serial line
  input  wire logic                 rx_in,
  output logic                      tx_out_q,
  // Interrupt requests
  output logic                      rx_irq_q,
  output logic                      tx_irq_q
);
  import ast_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [AST_CTL_WIDTH-1:0] ctrl_q;
  logic [15:0]              div_q;
  logic                     port_en;
  logic                     rx_run;
  logic                     tx_run;
  logic                     aw_ok_q;
  logic                     w_ok_q;
  logic [7:0]               aw_q;
  logic [31:0]              w_q;
  logic [3:0]               ws_q;

  assign port_en = ctrl_q[AST_CTL_PORT_EN];
  assign rx_run  = port_en && ctrl_q[AST_CTL_CONTINUOUS_RECEIVE_ENABLE] && !ctrl_q[AST_CTL_SYNC];
  assign tx_run  = port_en && ctrl_q[AST_CTL_TRANSMIT_ENABLE] && !ctrl_q[AST_CTL_SYNC];

  // ************************************************************
  // AXI write channel: address and data in either order
  // ************************************************************
  wire wr_fire = aw_ok_q && w_ok_q && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && aw_q == AST_OFS_CTRL;
  wire wr_tx   = wr_fire && aw_q == AST_OFS_TXDATA && ws_q[0];
  wire wr_div  = wr_fire && aw_q == AST_OFS_DIVISOR;
  wire wr_map  = aw_q == AST_OFS_CTRL || aw_q == AST_OFS_TXDATA || aw_q == AST_OFS_DIVISOR;

  function automatic logic [31:0] ast_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  wire [31:0] ctrl_new = ast_merge({17'h0, ctrl_q}, w_q, ws_q);
  wire [31:0] div_new  = ast_merge({16'h0, div_q}, w_q, ws_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q <= 1'b0;
      w_ok_q  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0;
      ws_q    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AST_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_q      <= 1'b0;
        w_ok_q       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? AST_RESP_OKAY : AST_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_ok_q;
  assign s_axi_wready  = !w_ok_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= AST_CTRL_RST;
      div_q  <= AST_DIVISOR_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new[AST_CTL_WIDTH-1:0];
      if (wr_div) div_q <= div_new[15:0];
    end
  end

  // ************************************************************
  // Shared baud tick generator
  // ************************************************************
  // Sixteen ticks per bit; base prescale 16 per bit with wide or high-speed set, 64 per bit with neither.
  logic [15:0] brg_q;
  logic [1:0]  pre_q;
  logic        tick;
  wire  [1:0]  pre_max = ctrl_q[AST_CTL_HISPEED] && ctrl_q[AST_CTL_WIDE] ? 2'd0 :
                         (ctrl_q[AST_CTL_HISPEED] || ctrl_q[AST_CTL_WIDE]) ? 2'd0 : 2'd3;
  wire  [15:0] brg_top = ctrl_q[AST_CTL_WIDE] ? div_q : {8'h00, div_q[7:0]};
  wire         brg_wrap = brg_q == 16'h0;
  assign tick = port_en && brg_wrap && pre_q == 2'd0;

  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en || wr_div) begin
      brg_q <= 16'h0;
      pre_q <= 2'd0;
    end else if (brg_wrap) begin
      brg_q <= brg_top;
      pre_q <= (pre_q == 2'd0) ? pre_max : pre_q - 2'd1;
    end else brg_q <= brg_q - 16'h1;
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  logic [8:0] thr_q;
  logic       thr_full_q;
  logic [9:0] tsr_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_ph_q;
  logic       tsr_busy_q;
  logic       tx_line_q;
  wire        tx_load = tx_run && thr_full_q && !tsr_busy_q;
  wire        tx_bit_end = tsr_busy_q && tick && tx_ph_q == 4'hf;

  always_ff @(posedge aclk) begin
    if (!aresetn || !port_en) begin
      thr_q      <= 9'h0;
      thr_full_q <= 1'b0;
      tsr_q      <= 10'h3ff;
      tx_bits_q  <= 4'h0;
      tx_ph_q    <= 4'h0;
      tsr_busy_q <= 1'b0;
      tx_line_q  <= 1'b1;
      tx_out_q   <= 1'b1;
    end else begin
      if (wr_tx) begin
        thr_q      <= {ctrl_q[AST_CTL_TRANSMIT_NINTH_BIT], w_q[7:0]};
        thr_full_q <= 1'b1;
      end else if (tx_load) thr_full_q <= 1'b0;
      if (tx_load) begin
        // Start bit first, then data least significant bit first, stop bits fill in.
        tsr_q      <= {thr_q, 1'b0};
        tx_bits_q  <= ctrl_q[AST_CTL_TX9] ? 4'd11 : 4'd10;
        tx_ph_q    <= 4'h0;
        tsr_busy_q <= 1'b1;
        tx_line_q  <= 1'b0;
      end else if (tsr_busy_q && tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
        if (tx_bit_end) begin
          tsr_q     <= {1'b1, tsr_q[9:1]};
          tx_line_q <= (tx_bits_q == 4'd2) ? 1'b1 : tsr_q[1];
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'd1) tsr_busy_q <= 1'b0;
        end
      end
      tx_out_q <= tx_line_q ^ ctrl_q[AST_CTL_TXINV];
    end
  end

  // ************************************************************
  // Receiver data recovery
  // ************************************************************
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } ast_rx_state_type;

  ast_rx_state_type rx_st_q;
  logic [3:0]       rx_ph_q;
  logic [3:0]       rx_cnt_q;
  logic [8:0]       rsr_q;
  logic [2:0]       vote_q;
  logic             rx_prev_q;
  logic             overflow_error_flag_q;
  logic             push;
  logic [9:0]       push_data;

  function automatic logic ast_major(input logic [2:0] s);
    return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  wire nine      = ctrl_q[AST_CTL_RX9];
  wire rx_center = tick && rx_ph_q == 4'h7;
  // Two samples just before the centre plus the centre itself; none reaches the next bit.
  wire rx_vote   = tick && (rx_ph_q == 4'h5 || rx_ph_q == 4'h6);
  wire bit_val   = ast_major({vote_q[1:0], rx_in});
  wire stop_done = rx_st_q == RX_STOP && rx_center;
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_st_q   <= RX_IDLE;
      rx_ph_q   <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rsr_q     <= 9'h0;
      vote_q    <= 3'h7;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
      if (rx_vote) vote_q <= {vote_q[1:0], rx_in};
      if (tick) rx_ph_q <= rx_ph_q + 4'h1;
      unique case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q <= 4'h0;
          if (rx_prev_q && !rx_in) rx_st_q <= RX_START;
        end
        RX_START: if (rx_center) begin
          rx_ph_q <= 4'h8;
          if (rx_in) rx_st_q <= RX_IDLE;
          else begin
            rx_st_q  <= RX_DATA;
            rx_cnt_q <= nine ? 4'd9 : 4'd8;
          end
        end
        RX_DATA: if (rx_center) begin
          // Arrives least significant bit first; shifting right lands it in order.
          rsr_q    <= nine ? {bit_val, rsr_q[8:1]} : {1'b0, bit_val, rsr_q[7:1]};
          rx_cnt_q <= rx_cnt_q - 4'h1;
          if (rx_cnt_q == 4'd1) rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rx_center) rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Stop sampled at its centre; framing error bit rides with the character.
  wire filt_ok = !(ctrl_q[AST_CTL_ADDRESS_FILTER_ENABLE] && nine) || rsr_q[8];
  wire fifo_full;
  assign push      = stop_done && filt_ok && !overflow_error_flag_q && !fifo_full;
  assign push_data = {!bit_val, rsr_q};

  // ************************************************************
  // Receive FIFO and overrun
  // ************************************************************
  logic [9:0] head;
  logic       not_empty;
  wire        rd_rx = s_axi_arvalid && s_axi_arready && s_axi_araddr == AST_OFS_RXDATA;

  ast_rx_fifo #(.WIDTH(10), .DEPTH(AST_FIFO_DEPTH)) u_fifo (
    .aclk        (aclk),
    .clear       (!aresetn || !port_en),
    .push        (push),
    .wdata       (push_data),
    .pop         (rd_rx),
    .head_q      (head),
    .not_empty_q (not_empty),
    .full_q      (fifo_full)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) overflow_error_flag_q <= 1'b0;
    else if (stop_done && filt_ok && fifo_full) overflow_error_flag_q <= 1'b1;
  end

  // ************************************************************
  // Flags and interrupts
  // ************************************************************
  wire receive_pending_flag = rx_run && not_empty;
  wire transmit_buffer_free_flag = tx_run && !thr_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= receive_pending_flag && ctrl_q[AST_CTL_RECEIVE_IRQ_ENABLE] && ctrl_q[AST_CTL_PERIPHERAL_IRQ_ENABLE]
                  && ctrl_q[AST_CTL_GIE];
      tx_irq_q <= transmit_buffer_free_flag && ctrl_q[AST_CTL_TRANSMIT_IRQ_ENABLE] && ctrl_q[AST_CTL_PERIPHERAL_IRQ_ENABLE] && ctrl_q[AST_CTL_GIE];
    end
  end

  // ************************************************************
  // AXI read channel
  // ************************************************************
  logic [6:0] sts;
  assign sts = {rx_st_q == RX_IDLE, !tsr_busy_q, transmit_buffer_free_flag, head[8], overflow_error_flag_q, head[9], receive_pending_flag};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AST_RESP_OKAY;
      unique case (s_axi_araddr)
        AST_OFS_CTRL:    s_axi_rdata <= {17'h0, ctrl_q};
        AST_OFS_STATUS:  s_axi_rdata <= {25'h0, sts};
        AST_OFS_TXDATA:  s_axi_rdata <= {23'h0, thr_q};
        AST_OFS_RXDATA:  s_axi_rdata <= {24'h0, head[7:0]};
        AST_OFS_DIVISOR: s_axi_rdata <= {16'h0, div_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AST_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_receive_pending_flag_follows;
    @(posedge aclk) disable iff (!aresetn)
      sts[AST_STS_RECEIVE_PENDING_FLAG] == (rx_run && u_fifo.cnt_q != 2'd0);
  endproperty
  a_receive_pending_flag_follows: assert property (p_receive_pending_flag_follows) else $error("pending high while off");

  property p_transmit_buffer_free_flag_on_enable;
    @(posedge aclk) disable iff (!aresetn)
      $rose(tx_run) && !thr_full_q |-> transmit_buffer_free_flag;
  endproperty
  a_transmit_buffer_free_flag_on_enable: assert property (p_transmit_buffer_free_flag_on_enable) else $error("buffer free missing");

  property p_overflow_error_flag_blocks;
    @(posedge aclk) disable iff (!aresetn) overflow_error_flag_q |=> u_fifo.cnt_q <= $past(u_fifo.cnt_q);
  endproperty
  a_overflow_error_flag_blocks: assert property (p_overflow_error_flag_blocks) else $error("push during overrun");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      rx_irq_q |-> $past(receive_pending_flag) && $past(ctrl_q[AST_CTL_GIE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enables");

  property p_idle_line;
    @(posedge aclk) disable iff (!aresetn)
      !tsr_busy_q && !$past(tsr_busy_q) ##1 !tsr_busy_q |-> tx_out_q == !ctrl_q[AST_CTL_TXINV]
        || $changed(ctrl_q);
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("idle level wrong");

  property p_start_abort;
    @(posedge aclk) disable iff (!aresetn)
      rx_st_q == RX_START && rx_center && rx_in && rx_run |=> rx_st_q == RX_IDLE;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("false start kept");

  property p_filter;
    @(posedge aclk) disable iff (!aresetn)
      push && ctrl_q[AST_CTL_ADDRESS_FILTER_ENABLE] && nine |-> rsr_q[8];
  endproperty
  a_filter: assert property (p_filter) else $error("non-address kept");

  property p_load_fast;
    @(posedge aclk) disable iff (!aresetn)
      tx_run && thr_full_q && !tsr_busy_q && !wr_tx |=> !thr_full_q && tsr_busy_q;
  endproperty
  a_load_fast: assert property (p_load_fast) else $error("held char not loaded");

endmodule

// ===== bench/ast_remote_node.sv
// Remote serial node model that drives the receive line and watches the transmit line.
`timescale 1ns/1ps
module ast_remote_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic aclk,
  output logic      line_q,
  input  wire logic tx_line
);
  // ************************************************************
  // Frame tasks
  // ************************************************************
  initial line_q = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    line_q <= 1'b0;
    repeat (BIT_CLKS) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      line_q <= d[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
    line_q <= stp;
    repeat (BIT_CLKS) @(posedge aclk);
    line_q <= 1'b1;
    repeat (BIT_CLKS) @(posedge aclk);
  endtask
  // A short low pulse that must not be taken for a start bit.
  task automatic glitch(input int n);
    line_q <= 1'b0;
    repeat (n) @(posedge aclk);
    line_q <= 1'b1;
  endtask
  // Samples each bit at its centre; the stop level is returned in ok.
  task automatic recv(output logic [8:0] d, input int nb, output logic ok);
    int n;
    n = 0;
    d = '0;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge aclk);
      d[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge aclk);
    ok = tx_line;
  endtask
endmodule

// ===== bench/ast_uart_tb_top.sv
// Self-checking bench for the asynchronous serial transceiver.
`timescale 1ns/1ps
module ast_uart_tb_top;
  import ast_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam logic [31:0] CTL = 32'h6a0b;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_in, tx_out_q, rx_irq_q, ok, ovf, txirq;
  logic [7:0]  awaddr, araddr, b;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [8:0]  d9;
  logic [9:0]  exp_q[$];
  int          mismatches, total_checks, seed;
  ast_uart uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_in(rx_in), .tx_out_q(tx_out_q),
    .rx_irq_q(rx_irq_q), .tx_irq_q(txirq));
  ast_remote_node rn (.aclk(aclk), .line_q(rx_in), .tx_line(tx_out_q));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Handshakes are judged at the rising edge where the slave samples them; the watchdog
  // is the only limit on a wait.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic       tb;
    logic [1:0] br;
    @(posedge aclk);
    tb = 1'b0;
    br = 2'b11;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      tb = bvalid;
      br = bresp;
    end
    bready <= 1'b0;
    chk("bresp", 32'(AST_RESP_OKAY), 32'(br));
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tr;
    @(posedge aclk);
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      tr = rvalid;
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
    chk("rvalid", 32'h1, 32'(tr));
  endtask
  // Reference FIFO: a full queue sets overrun and refuses further characters.
  task automatic mdl(input logic fe, input logic n9, input logic [7:0] c);
    if (exp_q.size() == 2) ovf = 1'b1;
    else if (!ovf) exp_q.push_back({fe, n9, c});
  endtask
  task automatic drain();
    logic [9:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      rdr(AST_OFS_STATUS, rd, rs);
      chk("status", {28'h0, e[8], ovf, e[9], 1'b1}, {28'h0, rd[3:0]});
      rdr(AST_OFS_RXDATA, rd, rs);
      chk("rxdata", {24'h0, e[7:0]}, {24'h0, rd[7:0]});
    end
    rdr(AST_OFS_STATUS, rd, rs);
    chk("pending", 32'h0, {31'h0, rd[0]});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ************************************************************
  // Clock, watchdog and sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial begin
    {seed, ovf, mismatches, total_checks} = {32'd61996, 1'b0, 64'd0};
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("tx idle", 32'h1, 32'(tx_out_q));
    rdr(8'h14, rd, rs);
    chk("unmapped", 32'(AST_RESP_SLVERR), 32'(rs));
    wr(AST_OFS_DIVISOR, 32'h0);
    wr(AST_OFS_CTRL, CTL);
    rdr(AST_OFS_STATUS, rd, rs);
    chk("buf free", 32'h1, 32'(rd[AST_STS_TRANSMIT_BUFFER_FREE_FLAG]));
    rn.glitch(4);
    repeat (200) @(posedge aclk);
    rdr(AST_OFS_STATUS, rd, rs);
    chk("glitch", 32'h0, 32'(rd[0]));
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      rn.send({1'b0, b}, 8, i != 0);
      mdl(i == 0, 1'b0, b);
    end
    chk("rx irq", 32'h1, 32'(rx_irq_q));
    rdr(AST_OFS_STATUS, rd, rs);
    chk("overrun", 32'h7, {29'h0, rd[2:0]});
    wr(AST_OFS_CTRL, CTL & ~32'h2);
    ovf = 1'b0;
    rdr(AST_OFS_STATUS, rd, rs);
    chk("ovf clear", 32'h2, {29'h0, rd[2:0]});
    wr(AST_OFS_CTRL, CTL);
    drain();
    rn.send(9'h055, 8, 1'b0);
    wr(AST_OFS_CTRL, CTL & ~32'h1);
    wr(AST_OFS_CTRL, CTL);
    rdr(AST_OFS_STATUS, rd, rs);
    chk("port off", 32'h0, {30'h0, rd[1:0]});
    wr(AST_OFS_CTRL, CTL | 32'h180);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      rn.send({i == 1, b}, 9, 1'b1);
      if (i > 0) mdl(1'b0, i == 1, b);
      if (i == 1) wr(AST_OFS_CTRL, CTL | 32'h80);
    end
    drain();
    for (int m = 0; m < 2; m++) begin
      b = 8'($random(seed));
      wr(AST_OFS_CTRL, CTL | (m == 1 ? 32'h30 : 32'h0));
      fork
        rn.recv(d9, 8 + m, ok);
        wr(AST_OFS_TXDATA, {24'h0, b});
      join
      chk("tx data", {23'h0, m[0], b}, {23'h0, d9});
      chk("tx stop", 32'h1, 32'(ok));
    end
    wr(AST_OFS_CTRL, CTL | 32'h1040);
    repeat (2) @(posedge aclk);
    chk("tx invert", 32'h0, 32'(tx_out_q));
    chk("tx irq", 32'h1, 32'(txirq));
    end_sim();
  end
endmodule
